// ### pkg/ccr_pkg.sv
// Package for the codec control register bank, registers 14 to 19.
// Assumes a register write/read port decoded from the serial or two-wire control path.
package ccr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register addresses
	localparam logic [7:0] ADDR_HEADSET_LINE_POWER_CONTROL = 8'h0E;
	localparam logic [7:0] ADDR_FIRST_CODEC_FORMAT_CONFIG = 8'h0F;
	localparam logic [7:0] ADDR_SECOND_CODEC_FORMAT_CONFIG = 8'h10;
	localparam logic [7:0] ADDR_CONTROL_FRAME_SPACING = 8'h11;
	localparam logic [7:0] ADDR_RESERVED_A = 8'h12;
	localparam logic [7:0] ADDR_RESERVED_B = 8'h13;

	// Reset values
	localparam logic [7:0] RST_HEADSET_LINE_POWER_CONTROL = 8'h00;
	localparam logic [7:0] RST_CODEC_FORMAT_CONFIG = 8'h00;
	localparam logic [7:0] RST_CONTROL_FRAME_SPACING = 8'h00;
	localparam logic [7:0] RST_RESERVED = 8'h00;

	// Register 14 field positions
	localparam int HS_MUTE_BIT = 7;
	localparam int LINE_POLE_HI = 6;
	localparam int LINE_POLE_LO = 5;
	localparam int HS_ECHO_HI = 4;
	localparam int HS_ECHO_LO = 2;
	localparam int ANALOG_PD_BIT = 1;
	localparam int LINE_PD_BIT = 0;

	// Codec configuration field positions
	localparam int COMPAND_EN_BIT = 7;
	localparam int COMPAND_MU_BIT = 6;
	localparam int ZC_ADC_DIS_BIT = 5;
	localparam int ZC_DAC_DIS_BIT = 4;
	localparam int HIGHPASS_BYPASS_BIT = 3;
	localparam int ZC_DIS_BIT = 2;
	localparam int ZC_THR_HI = 1;
	localparam int ZC_THR_LO = 0;

	// Echo gain code that mutes the echo path
	localparam logic [2:0] ECHO_MUTE_CODE = 3'h7;
	// Echo gain at code zero and step, in dB of attenuation
	localparam logic [4:0] ECHO_BASE_DB = 5'h0C;
	localparam logic [4:0] ECHO_STEP_DB = 5'h02;

	// Zero-crossing threshold in LSBs per code
	localparam logic [3:0] ZC_THR_CODE0 = 4'h6;
	localparam logic [3:0] ZC_THR_CODE1 = 4'h4;
	localparam logic [3:0] ZC_THR_CODE2 = 4'h8;
	localparam logic [3:0] ZC_THR_CODE3 = 4'hA;

	typedef enum logic [1:0] {
		POLE_64K = 2'b00,
		POLE_32K = 2'b01,
		POLE_21K3 = 2'b10,
		POLE_16K = 2'b11
	} ccr_pole_e;

	typedef enum logic [1:0] {
		CMP_LINEAR = 2'b00,
		CMP_ALAW = 2'b10,
		CMP_MULAW = 2'b11
	} ccr_compand_e;

	// Decoded controls of one codec
	typedef struct packed {
		ccr_compand_e compand;
		logic zc_adc_en;
		logic zc_dac_en;
		logic zc_en;
		logic adc_highpass_stage_bypass;
		logic [3:0] zc_threshold;
	} ccr_codec_ctl_s;

	// Decoded controls of register 14
	typedef struct packed {
		logic headset_out_en;
		ccr_pole_e line_pole;
		logic echo_mute;
		logic [4:0] echo_atten_db;
		logic analog_power_down;
		logic line_out_en;
		logic line_in_en;
		logic common_mode_reference_en;
	} ccr_analog_ctl_s;

	// Register write/read port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccr_req_s;

	// All state of the bank
	typedef struct packed {
		logic [7:0] headset_line_power_control;
		logic [7:0] first_codec_format_config;
		logic [7:0] second_codec_format_config;
		logic [7:0] control_frame_spacing;
		logic [7:0] rdata;
		logic rvalid;
		logic hit;
	} ccr_state_s;
endpackage

// ### hdl/ccr_regs.sv
// Codec control register bank: registers 14 to 19 and their decoded controls.
// Assumes the control interface delivers synchronous one-cycle write/read strobes.
//
// Function
// - Register 14 bit 7 set mutes the headset output, clear keeps it enabled.
// - Register 14 bits 6:5 pick the line amplifier pole of 64, 32, 21.3 or 16 kHz.
// - Register 14 bits 4:2 set headset echo gain from -12 to -24 dB in 2 dB steps, code 7 mutes.
// - Register 14 bit 1 set powers down the whole analog section.
// - Register 14 bit 0 set powers down line output, line input and floats the common-mode reference.
// - Codec bits 7:6 pick linear when bit 7 is clear, A-law for 10 and mu-law for 11.
// - Codec bits 5, 4 and 2 disable zero crossing for ADC, DAC and in general when set.
// - Codec bit 3 set bypasses that codec's ADC high-pass stage.
// - Codec bits 1:0 give a zero-crossing threshold of 6, 4, 8 or 10 LSBs.
// - Codec 1 config sits at address 0x0F and codec 2 config at 0x10, same layout.
// - Register 17 counts frames without control information between control frames, zero means every frame.
`timescale 1ns/100ps

module ccr_regs
	import ccr_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Register port
	input wire ccr_req_s REQ,
	output logic [7:0] RDATA,
	output logic RVALID,
	output logic ADDR_HIT,
	// Decoded analog and codec controls
	output ccr_analog_ctl_s ANALOG_CTL,
	output ccr_codec_ctl_s CODEC1_CTL,
	output ccr_codec_ctl_s CODEC2_CTL,
	// Frame spacing and raw views
	output logic [7:0] CONTROL_FRAME_SPACING,
	output logic CTRL_EVERY_FRAME
);

	ccr_state_s state;
	ccr_state_s next_state;

	// Decodes one codec configuration byte
	function automatic ccr_codec_ctl_s decode_codec(input logic [7:0] cfg);
		ccr_codec_ctl_s c;
		c.compand = !cfg[COMPAND_EN_BIT] ? CMP_LINEAR
			: (cfg[COMPAND_MU_BIT] ? CMP_MULAW : CMP_ALAW);
		c.zc_adc_en = !cfg[ZC_ADC_DIS_BIT];
		c.zc_dac_en = !cfg[ZC_DAC_DIS_BIT];
		c.zc_en = !cfg[ZC_DIS_BIT];
		c.adc_highpass_stage_bypass = cfg[HIGHPASS_BYPASS_BIT];
		unique case (cfg[ZC_THR_HI:ZC_THR_LO])
			2'b00: c.zc_threshold = ZC_THR_CODE0;
			2'b01: c.zc_threshold = ZC_THR_CODE1;
			2'b10: c.zc_threshold = ZC_THR_CODE2;
			2'b11: c.zc_threshold = ZC_THR_CODE3;
		endcase
		return c;
	endfunction

	// Echo attenuation in dB for a code below the mute code
	function automatic logic [4:0] echo_db(input logic [2:0] code);
		logic [7:0] prod;
		prod = 8'({5'h00, code} * 8'(ECHO_STEP_DB));
		return 5'(ECHO_BASE_DB + prod[4:0]);
	endfunction

	always_comb begin
		logic hit;
		hit = 1'b0;
		next_state = state;
		next_state.rvalid = REQ.rd;
		unique case (REQ.addr)
			ADDR_HEADSET_LINE_POWER_CONTROL,
			ADDR_FIRST_CODEC_FORMAT_CONFIG,
			ADDR_SECOND_CODEC_FORMAT_CONFIG,
			ADDR_CONTROL_FRAME_SPACING,
			ADDR_RESERVED_A,
			ADDR_RESERVED_B: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		next_state.hit = (REQ.rd || REQ.wr) && hit;
		if (REQ.wr) begin
			unique case (REQ.addr)
				ADDR_HEADSET_LINE_POWER_CONTROL: next_state.headset_line_power_control = REQ.wdata;
				ADDR_FIRST_CODEC_FORMAT_CONFIG: next_state.first_codec_format_config = REQ.wdata;
				ADDR_SECOND_CODEC_FORMAT_CONFIG: next_state.second_codec_format_config = REQ.wdata;
				ADDR_CONTROL_FRAME_SPACING: next_state.control_frame_spacing = REQ.wdata;
				// Reserved and unmapped writes are dropped
				default: next_state.rdata = state.rdata;
			endcase
		end
		if (REQ.rd) begin
			unique case (REQ.addr)
				ADDR_HEADSET_LINE_POWER_CONTROL: next_state.rdata = state.headset_line_power_control;
				ADDR_FIRST_CODEC_FORMAT_CONFIG: next_state.rdata = state.first_codec_format_config;
				ADDR_SECOND_CODEC_FORMAT_CONFIG: next_state.rdata = state.second_codec_format_config;
				ADDR_CONTROL_FRAME_SPACING: next_state.rdata = state.control_frame_spacing;
				default: next_state.rdata = RST_RESERVED;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state.headset_line_power_control <= RST_HEADSET_LINE_POWER_CONTROL;
			state.first_codec_format_config <= RST_CODEC_FORMAT_CONFIG;
			state.second_codec_format_config <= RST_CODEC_FORMAT_CONFIG;
			state.control_frame_spacing <= RST_CONTROL_FRAME_SPACING;
			state.rdata <= 8'h00;
			state.rvalid <= 1'b0;
			state.hit <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign RDATA = state.rdata;
	assign RVALID = state.rvalid;
	assign ADDR_HIT = state.hit;

	always_comb begin
		logic [7:0] r;
		r = state.headset_line_power_control;
		ANALOG_CTL.headset_out_en = !r[HS_MUTE_BIT];
		ANALOG_CTL.line_pole = ccr_pole_e'(r[LINE_POLE_HI:LINE_POLE_LO]);
		ANALOG_CTL.echo_mute = (r[HS_ECHO_HI:HS_ECHO_LO] == ECHO_MUTE_CODE);
		ANALOG_CTL.echo_atten_db = ANALOG_CTL.echo_mute ? 5'h00 : echo_db(r[HS_ECHO_HI:HS_ECHO_LO]);
		ANALOG_CTL.analog_power_down = r[ANALOG_PD_BIT];
		ANALOG_CTL.line_out_en = !r[LINE_PD_BIT];
		ANALOG_CTL.line_in_en = !r[LINE_PD_BIT];
		ANALOG_CTL.common_mode_reference_en = !r[LINE_PD_BIT];
	end

	assign CODEC1_CTL = decode_codec(state.first_codec_format_config);
	assign CODEC2_CTL = decode_codec(state.second_codec_format_config);
	assign CONTROL_FRAME_SPACING = state.control_frame_spacing;
	assign CTRL_EVERY_FRAME = (state.control_frame_spacing == 8'h00);

endmodule // ccr_regs

// ### dv/ccr_regs_asserts.sv
// Checker for the codec control register bank.
// Bound to ccr_regs; sees only its ports.
`timescale 1ns/100ps
module ccr_regs_asserts
	import ccr_pkg::*;
(
	// Clock, reset, register port
	input wire logic CLK,
	input wire logic RESETN,
	input wire ccr_req_s REQ,
	input wire logic [7:0] RDATA,
	input wire logic RVALID,
	// Decoded controls
	input wire ccr_analog_ctl_s ANALOG_CTL,
	input wire ccr_codec_ctl_s CODEC1_CTL,
	input wire ccr_codec_ctl_s CODEC2_CTL,
	input wire logic CTRL_EVERY_FRAME
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	wire w14 = REQ.wr && REQ.addr == 8'h0E;
	a_hs_mute: assert property (w14 |=> ANALOG_CTL.headset_out_en == !$past(REQ.wdata[7]))
		else $error("headset enable wrong");
	a_line_pole: assert property (w14 |=> ANALOG_CTL.line_pole == $past(REQ.wdata[6:5]))
		else $error("line pole wrong");
	a_echo_mute: assert property (w14 |=> ANALOG_CTL.echo_mute == ($past(REQ.wdata[4:2]) == 3'h7))
		else $error("echo mute wrong");
	a_analog_pd: assert property (w14 |=> ANALOG_CTL.analog_power_down == $past(REQ.wdata[1]))
		else $error("analog power down wrong");
	a_line_path: assert property (w14 |=> ANALOG_CTL.line_in_en == !$past(REQ.wdata[0]) &&
		ANALOG_CTL.common_mode_reference_en == ANALOG_CTL.line_in_en) else $error("line path wrong");
	a_codec1_mode: assert property (REQ.wr && REQ.addr == 8'h0F |=>
		CODEC1_CTL.compand == ($past(REQ.wdata[7]) ? $past(REQ.wdata[7:6]) : 2'b00)) else $error("mode wrong");
	a_codec2_zc: assert property (REQ.wr && REQ.addr == 8'h10 |=> CODEC2_CTL.zc_en == !$past(REQ.wdata[2]))
		else $error("codec 2 zero crossing wrong");
	a_codec1_bypass: assert property (REQ.wr && REQ.addr == 8'h0F |=>
		CODEC1_CTL.adc_highpass_stage_bypass == $past(REQ.wdata[3])) else $error("codec 1 bypass wrong");
	a_codec2_thr: assert property (REQ.wr && REQ.addr == 8'h10 |=> CODEC2_CTL.zc_threshold ==
		($past(REQ.wdata[1]) ? ($past(REQ.wdata[0]) ? 4'hA : 4'h8) : ($past(REQ.wdata[0]) ? 4'h4 : 4'h6)))
		else $error("codec 2 threshold wrong");
	a_every_frame: assert property (REQ.wr && REQ.addr == 8'h11 |=> CTRL_EVERY_FRAME == ($past(REQ.wdata) == 8'h00))
		else $error("every frame flag wrong");
	a_rsvd_zero: assert property (REQ.rd && REQ.addr inside {8'h12, 8'h13} |=> RVALID && RDATA == 8'h00)
		else $error("reserved read not zero");
endmodule // ccr_regs_asserts
bind ccr_regs ccr_regs_asserts i_chk (.CLK, .RESETN, .REQ, .RDATA, .RVALID, .ANALOG_CTL, .CODEC1_CTL,
	.CODEC2_CTL, .CTRL_EVERY_FRAME);

// ### dv/ccr_host.sv
// Host model issuing single-byte register writes and reads.
// Assumes the bank takes one-cycle strobes on the rising edge.
`timescale 1ns/100ps
module ccr_host
	import ccr_pkg::*;
(
	// Clock and bank side
	input wire logic CLK,
	input wire logic [7:0] RDATA,
	output ccr_req_s REQ
);
	initial REQ = '0;
	// Released lines show inverted values
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge CLK);
		#1 REQ = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge CLK);
		#1 q = RDATA;
		REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule // ccr_host

// ### dv/ccr_regs_tb.sv
// Testbench for the codec control register bank.
// Assumes ccr_host drives the register port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module ccr_regs_tb import ccr_pkg::*; ;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	ccr_req_s req;
	logic [7:0] rdata, spc;
	logic rvalid, hit, every;
	ccr_analog_ctl_s an;
	ccr_codec_ctl_s c1, c2;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	ccr_host i_host (.CLK, .RDATA(rdata), .REQ(req));
	ccr_regs i_dut (.CLK, .RESETN, .REQ(req), .RDATA(rdata), .RVALID(rvalid), .ADDR_HIT(hit), .ANALOG_CTL(an),
		.CODEC1_CTL(c1), .CODEC2_CTL(c2), .CONTROL_FRAME_SPACING(spc), .CTRL_EVERY_FRAME(every));
	initial begin
		forever #5 CLK = ~CLK;
	end
	function automatic logic [3:0] thr(logic [1:0] c);
		return c == 0 ? 4'h6 : c == 1 ? 4'h4 : c == 2 ? 4'h8 : 4'hA;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_reset;
		logic [7:0] q;
		`CHK("hs_en", 1'b1, an.headset_out_en)
		`CHK("echo_db", 5'h0C, an.echo_atten_db)
		`CHK("every", 1'b1, every)
		for (int a = 14; a <= 19; a++) begin
			i_host.xfer(1'b0, 8'(a), 8'h00, q);
			`CHK("rst_rd", 8'h00, q)
		end
		$display("test reset done");
	endtask
	task automatic t_reg14;
		logic [7:0] q, v;
		for (int k = 0; k < 8; k++) begin
			v = {k[0], k[1:0], k[2:0], k[1], k[0]};
			i_host.xfer(1'b1, 8'h0E, v, q);
			`CHK("hs_en", !v[7], an.headset_out_en)
			`CHK("pole", v[6:5], an.line_pole)
			`CHK("mute", k == 7, an.echo_mute)
			`CHK("echo_db", (k == 7) ? 5'h00 : 5'(12 + 2 * k), an.echo_atten_db)
			`CHK("apd", v[1], an.analog_power_down)
			`CHK("line", {3{!v[0]}}, {an.line_out_en, an.line_in_en, an.common_mode_reference_en})
			i_host.xfer(1'b0, 8'h0E, 8'h00, q);
			`CHK("rd14", v, q)
		end
		$display("test reg14 done");
	endtask
	task automatic t_codec;
		logic [7:0] q, v;
		for (int k = 0; k < 4; k++) begin
			v = {k[1:0], k[0], !k[0], k[1], k[0], k[1:0]};
			i_host.xfer(1'b1, 8'h0F, v, q);
			i_host.xfer(1'b1, 8'h10, ~v, q);
			`CHK("mode1", v[7] ? v[7:6] : 2'b00, c1.compand)
			`CHK("mode2", !v[7] ? ~v[7:6] : 2'b00, c2.compand)
			`CHK("zc1", ~v[5:4], {c1.zc_adc_en, c1.zc_dac_en})
			`CHK("zcen2", v[2], c2.zc_en)
			`CHK("zcen1", !v[2], c1.zc_en)
			`CHK("zc2", v[5:4], {c2.zc_adc_en, c2.zc_dac_en})
			`CHK("hp1", v[3], c1.adc_highpass_stage_bypass)
			`CHK("hp2", !v[3], c2.adc_highpass_stage_bypass)
			`CHK("thr1", thr(v[1:0]), c1.zc_threshold)
			`CHK("thr2", thr(~v[1:0]), c2.zc_threshold)
		end
		$display("test codec done");
	endtask
	task automatic t_misc;
		logic [7:0] q;
		i_host.xfer(1'b1, 8'h11, 8'hFF, q);
		`CHK("spc", 8'hFF, spc)
		`CHK("every", 1'b0, every)
		`CHK("rv_wr", 1'b0, rvalid)
		i_host.xfer(1'b1, 8'h20, 8'h5A, q);
		`CHK("hit", 1'b0, hit)
		i_host.xfer(1'b0, 8'h11, 8'h00, q);
		`CHK("rd17", 8'hFF, q)
		`CHK("rv_rd", 1'b1, rvalid)
		`CHK("hit", 1'b1, hit)
		i_host.xfer(1'b1, 8'h12, 8'h00, q);
		`CHK("hit_rsvd", 1'b1, hit)
		i_host.xfer(1'b0, 8'h12, 8'h00, q);
		`CHK("rd18", 8'h00, q)
		i_host.xfer(1'b1, 8'h11, 8'h00, q);
		`CHK("every", 1'b1, every)
		$display("test misc done");
	endtask
	task automatic t_midreset;
		logic [7:0] q;
		i_host.xfer(1'b1, 8'h11, 8'h3C, q);
		@(posedge CLK);
		#1 RESETN = 1'b0;
		@(posedge CLK);
		#1 RESETN = 1'b1;
		`CHK("mr_every", 1'b1, every)
		`CHK("mr_hs_en", 1'b1, an.headset_out_en)
		`CHK("mr_mode1", 2'b00, c1.compand)
		`CHK("mr_hit", 1'b0, hit)
		i_host.xfer(1'b0, 8'h0E, 8'h00, q);
		`CHK("mr_rd14", 8'h00, q)
		$display("test midreset done");
	endtask
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge CLK);
		#1 RESETN = 1'b1;
		t_reset();
		t_reg14();
		t_codec();
		t_misc();
		t_midreset();
		conclude();
	end
endmodule // ccr_regs_tb
